// ===== core/sspr_pkg.sv
// Package: constants and carriers of the stepper serial register port
package sspr_pkg;

   // ---------------------------------------------------------------
   // Framing and register select
   // ---------------------------------------------------------------
   localparam logic [4:0] FULL_COUNT   = 5'h10;  // Bits in a word
   localparam logic [4:0] OVER_COUNT   = 5'h11;  // Saturation mark
   localparam logic [1:0] SEL_SYS_CFG  = 2'h0;   // Address bits 15:14
   localparam logic [1:0] SEL_DIAG_CFG = 2'h1;
   localparam logic [1:0] SEL_RUN      = 2'h2;
   localparam logic [1:0] SEL_TABLE    = 2'h3;

   // ---------------------------------------------------------------
   // Values after power-on reset
   // ---------------------------------------------------------------
   localparam logic [15:0] SYS_CFG_RST  = 16'h2712;
   localparam logic [15:0] DIAG_CFG_RST = 16'h5020;
   localparam logic [15:0] RUN_RST      = 16'h8A80;
   localparam logic [7:0]  SHORT_POR    = 8'hFF;
   localparam logic [5:0]  FLAGS_POR    = 6'h3F;

   // ---------------------------------------------------------------
   // Phase table
   // ---------------------------------------------------------------
   typedef logic [5:0] sspr_level_t;
   localparam logic [4:0] TABLE_LEN = 5'h10;     // Index value "done"
   // Default quarter-wave profile, first entry is the smallest step
   localparam sspr_level_t DEFAULT_PROFILE [16] = '{
      6'h06, 6'h0C, 6'h12, 6'h18, 6'h1E, 6'h23, 6'h28, 6'h2D,
      6'h31, 6'h34, 6'h38, 6'h3A, 6'h3C, 6'h3E, 6'h3F, 6'h3F};

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SYS_PERIOD_NS = 20;            // 50 MHz system clock
   localparam int RST_PULSE_NS  = 1000;          // External reset width
   localparam int RST_CYCLES    =
      (RST_PULSE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CORE_CLK_MHZ  = 4;             // Decay timing clock
   localparam logic [6:0] FAST_DECAY_US [8] = '{
      7'h02, 7'h03, 7'h04, 7'h06, 7'h08, 7'h0A, 7'h0E, 7'h14};
   localparam logic [6:0] MAX_CURRENT_PCT [4] = '{
      7'h19, 7'h32, 7'h4B, 7'h64};
   // Table angle advance per step: full, half, quarter, sixteenth
   localparam logic [4:0] STEP_INC [4] = '{5'h10, 5'h08, 5'h04, 5'h01};

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       synchronous_rectify_enable;
      logic [1:0] microstep_select;
      logic [1:0] max_current_select;
      logic [2:0] fast_decay_time_select;
      logic [1:0] blank_select;
      logic [2:0] time_select;                   // Off time or period
      logic       fixed_frequency;
   } sspr_sys_cfg_t;

   typedef struct packed {
      logic [1:0] thermal_warn;
      logic       undervoltage;
      logic       stall;
      logic       open_load_b;
      logic       open_load_a;
   } sspr_flags_t;

   typedef struct packed {
      logic        poll;                         // No clock edge seen
      logic [4:0]  cnt;
      logic [15:0] word;
   } sspr_frame_t;

endpackage

// ===== core/sspr_port.sv
// Serial register port: link shifter, register bank, diagnostics, table
module sspr_port #(
   parameter int RST_CYCLES = sspr_pkg::RST_CYCLES
) (
   // System clock and power-on reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   // Serial link pins
   input  wire logic                    serial_clk_i,
   input  wire logic                    serial_strobe_n_i,
   input  wire logic                    serial_data_i,
   output logic                         serial_data_o,
   output logic                         serial_data_oe_o,
   // External reset pin
   input  wire logic                    external_reset_n_i,
   // Fault sources and step angle from the driver core
   input  wire sspr_pkg::sspr_flags_t   flag_set_i,
   input  wire logic [7:0]              short_fault_i,
   input  wire logic [5:0]              step_angle_i,
   // Phase current lookup
   input  wire logic [5:0]              table_angle_i,
   output sspr_pkg::sspr_level_t        phase_a_level_o,
   output sspr_pkg::sspr_level_t        phase_b_level_o,
   // Configuration outputs
   output sspr_pkg::sspr_sys_cfg_t      system_configuration_o,
   output logic [15:0]                  diag_configuration_o,
   output logic [15:0]                  run_o,
   output logic [4:0]                   step_increment_o,
   output logic [6:0]                   max_current_pct_o,
   output logic [6:0]                   fast_decay_cycles_o,
   output logic [2:0]                   off_time_select_o,
   output logic [2:0]                   period_select_o
);

   // ---------------------------------------------------------------
   // Frame marker on the strobe's own falling edge
   // ---------------------------------------------------------------
   logic              frame_tgl;     // Set opposite to frame_seen at each strobe fall
   logic              frame_seen;    // Link copy, taken at first edge
   logic              first_edge;    // No clock edge yet this frame
   logic [4:0]        bit_cnt;       // Saturates above sixteen
   logic [15:0]       shift_word;    // Incoming word
   logic [1:0]        link_sel;      // Address bits as they arrive
   // Link clock may stand still, so the strobe itself marks the frame;
   // set apart from the link copy, so a poll cannot leave it matching
   always_ff @(negedge serial_strobe_n_i or posedge rst_i) begin
      if (rst_i) begin
         frame_tgl <= 1'b0;
      end else begin
         frame_tgl <= ~frame_seen;
      end
   end
   assign first_edge = frame_seen != frame_tgl;

   // ---------------------------------------------------------------
   // Link domain: shifter and edge counter
   // ---------------------------------------------------------------
   // Sample on rising edge, only while strobe is low
   always_ff @(posedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_word <= 16'h0000;
         frame_seen <= 1'b0;
      end else if (!serial_strobe_n_i) begin
         shift_word <= {shift_word[14:0], serial_data_i};
         frame_seen <= frame_tgl;
      end
   end
   // Counter restarts at the first edge of each frame
   always_ff @(posedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bit_cnt <= 5'h00;
      end else if (!serial_strobe_n_i) begin
         if (first_edge) begin
            bit_cnt <= 5'h01;
         end else if (bit_cnt != sspr_pkg::OVER_COUNT) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end
   // Address bits captured for the output select
   always_ff @(posedge serial_clk_i or posedge rst_i) begin
      if (rst_i) begin
         link_sel <= 2'h0;
      end else if (!serial_strobe_n_i) begin
         if (first_edge) begin
            link_sel <= {serial_data_i, 1'b0};
         end else if (bit_cnt == 5'h01) begin
            link_sel[0] <= serial_data_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // Serial output
   // ---------------------------------------------------------------
   logic [15:0]       short_hold;    // Snapshots frozen during frame
   logic [15:0]       step_hold;
   logic [4:0]        out_idx;
   logic [15:0]       out_word;
   // Top bits are shared, so select only matters after two bits
   always_comb begin
      out_idx  = first_edge ? 5'h00 : bit_cnt;
      out_word = short_hold;
      if (!first_edge && bit_cnt >= 5'h02 &&
          link_sel == sspr_pkg::SEL_DIAG_CFG) begin
         out_word = step_hold;
      end
      serial_data_o = 1'b0;
      if (out_idx < sspr_pkg::FULL_COUNT) begin
         serial_data_o = out_word[4'(5'h0F - out_idx)];
      end
   end
   // Driven for the whole time the strobe is low
   assign serial_data_oe_o = ~serial_strobe_n_i;

   // ---------------------------------------------------------------
   // System domain: synchronisers
   // ---------------------------------------------------------------
   logic [1:0]            strobe_sync;
   logic                  strobe_prev;
   logic                  end_evt;       // Strobe rise seen
   sspr_pkg::sspr_frame_t frm_meta;      // First stage, not read
   sspr_pkg::sspr_frame_t frm;           // Quasi-static at end_evt
   logic [1:0]            xrst_sync;
   logic [15:0]           xrst_cnt;
   logic                  xrst_hit;      // Reset held long enough
   // Strobe and frame result cross with two flops each
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         strobe_sync <= 2'h3;
         strobe_prev <= 1'b1;
         frm_meta    <= '0;
         frm         <= '0;
      end else begin
         strobe_sync <= {strobe_sync[0], serial_strobe_n_i};
         strobe_prev <= strobe_sync[1];
         frm_meta    <= {first_edge, bit_cnt, shift_word};
         frm         <= frm_meta;
      end
   end
   assign end_evt = strobe_sync[1] & ~strobe_prev;
   // External reset pin width filter
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         xrst_sync <= 2'h3;
         xrst_cnt  <= 16'h0000;
      end else begin
         xrst_sync <= {xrst_sync[0], external_reset_n_i};
         if (xrst_sync[1]) begin
            xrst_cnt <= 16'h0000;
         end else if (xrst_cnt < 16'(RST_CYCLES)) begin
            xrst_cnt <= xrst_cnt + 16'h0001;
         end
      end
   end
   assign xrst_hit = !xrst_sync[1] && xrst_cnt >= 16'(RST_CYCLES - 1);

   // ---------------------------------------------------------------
   // Frame classification and register bank
   // ---------------------------------------------------------------
   logic                    frame_ok;
   logic                    frame_err;
   logic                    wr_ok;
   logic [1:0]              sel;
   sspr_pkg::sspr_sys_cfg_t sys_cfg;
   logic [15:0]             diag_cfg;
   logic [15:0]             run_reg;
   // A poll with no clock edge is neither a write nor an error
   assign frame_ok  = !frm.poll && frm.cnt == sspr_pkg::FULL_COUNT;
   assign frame_err = end_evt && !frm.poll && !frame_ok;
   assign wr_ok     = end_evt && frame_ok;
   assign sel       = frm.word[15:14];
   // Writable registers; external reset restores defaults
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sys_cfg  <= sspr_pkg::sspr_sys_cfg_t'(sspr_pkg::SYS_CFG_RST[13:0]);
         diag_cfg <= sspr_pkg::DIAG_CFG_RST;
         run_reg  <= sspr_pkg::RUN_RST;
      end else if (xrst_hit) begin
         sys_cfg  <= sspr_pkg::sspr_sys_cfg_t'(sspr_pkg::SYS_CFG_RST[13:0]);
         diag_cfg <= sspr_pkg::DIAG_CFG_RST;
         run_reg  <= sspr_pkg::RUN_RST;
      end else if (wr_ok) begin
         case (sel)
            sspr_pkg::SEL_SYS_CFG:
               sys_cfg <= sspr_pkg::sspr_sys_cfg_t'(frm.word[13:0]);
            sspr_pkg::SEL_DIAG_CFG: diag_cfg <= frm.word;
            sspr_pkg::SEL_RUN:      run_reg  <= frm.word;
            default: ;                                        // Table port
         endcase
      end
   end
   // Settings decoded for the driver core, one cycle after a write
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         step_increment_o    <= 5'h00;
         max_current_pct_o   <= 7'h00;
         fast_decay_cycles_o <= 7'h00;
         off_time_select_o   <= 3'h0;
         period_select_o     <= 3'h0;
      end else begin
         step_increment_o  <=
            sspr_pkg::STEP_INC[sys_cfg.microstep_select];
         max_current_pct_o <=
            sspr_pkg::MAX_CURRENT_PCT[sys_cfg.max_current_select];
         fast_decay_cycles_o <= 7'(sspr_pkg::FAST_DECAY_US[
            sys_cfg.fast_decay_time_select] * sspr_pkg::CORE_CLK_MHZ);
         // Unused view reads zero
         off_time_select_o <= sys_cfg.fixed_frequency ?
            3'h0 : sys_cfg.time_select;
         period_select_o   <= sys_cfg.fixed_frequency ?
            sys_cfg.time_select : 3'h0;
      end
   end
   assign system_configuration_o = sys_cfg;
   assign diag_configuration_o   = diag_cfg;
   assign run_o                  = run_reg;

   // ---------------------------------------------------------------
   // Phase table loader
   // ---------------------------------------------------------------
   logic [4:0]            tbl_idx;     // TABLE_LEN means full
   logic                  tbl_wr;
   logic                  tbl_take;
   logic                  par_bad;
   sspr_pkg::sspr_level_t tbl_mem [16];

   assign tbl_wr   = wr_ok && sel == sspr_pkg::SEL_TABLE;
   assign tbl_take = tbl_wr && tbl_idx != sspr_pkg::TABLE_LEN;
   assign par_bad  = tbl_take && !(^frm.word[6:0]);
   // Index restarts on any break in the sequence
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         tbl_idx <= 5'h00;
      end else if (xrst_hit || frame_err) begin
         tbl_idx <= 5'h00;
      end else if (wr_ok && sel != sspr_pkg::SEL_TABLE) begin
         tbl_idx <= 5'h00;
      end else if (tbl_take) begin
         tbl_idx <= tbl_idx + 5'h01;
      end
   end
   // Only power-on restores the profile; bad parity is still stored
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 16; i++) begin
            tbl_mem[i] <= sspr_pkg::DEFAULT_PROFILE[i];
         end
      end else if (tbl_take) begin
         tbl_mem[tbl_idx[3:0]] <= frm.word[5:0];
      end
   end
   // One quadrant mirrored: rising, falling, and phase B offset
   function automatic sspr_pkg::sspr_level_t level_at(
      input logic [5:0] a
   );
      logic [3:0] q;
      q = a[3:0];
      if (!a[4]) begin
         level_at = (q == 4'h0) ? 6'h00 : tbl_mem[4'(q - 4'h1)];
      end else begin
         level_at = tbl_mem[4'(4'hF - q)];
      end
   endfunction
   // Magnitudes per phase; sign is the core's business
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         phase_a_level_o <= 6'h00;
         phase_b_level_o <= 6'h00;
      end else begin
         phase_a_level_o <= level_at(table_angle_i);
         phase_b_level_o <= level_at(6'(table_angle_i + 6'h10));
      end
   end

   // ---------------------------------------------------------------
   // Diagnostic registers
   // ---------------------------------------------------------------
   logic        clr_diag;
   logic [7:0]  short_flags;
   logic [5:0]  flag_reg;
   logic        xfer_err;
   logic        par_err;
   logic        fault_flag;

   assign clr_diag = wr_ok || xrst_hit;
   // Sticky faults; a new fault beats a same-cycle clear
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         short_flags <= sspr_pkg::SHORT_POR;
         flag_reg    <= sspr_pkg::FLAGS_POR;
      end else begin
         short_flags <= (clr_diag ? 8'h00 : short_flags) | short_fault_i;
         flag_reg    <= (clr_diag ? 6'h00 : flag_reg) | flag_set_i;
      end
   end
   // Aborted writes do not clear, they flag
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         xfer_err <= 1'b0;
         par_err  <= 1'b0;
      end else begin
         xfer_err <= frame_err | (xfer_err & ~clr_diag);
         par_err  <= par_bad | (par_err & ~clr_diag);
      end
   end
   assign fault_flag = (|short_flags) | (|flag_reg) |
                       xfer_err | par_err;
   // Snapshot for the output pin, frozen while strobe is low
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         short_hold <= 16'h0000;
         step_hold  <= 16'h0000;
      end else if (strobe_sync[1]) begin
         short_hold <= {fault_flag, flag_reg[5:4], 1'b0,
                        flag_reg[3:0], short_flags};
         step_hold  <= {fault_flag, flag_reg[5:4], 1'b0,
                        flag_reg[3:0], 2'h0, step_angle_i};
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   sequence s_good_end;
      end_evt && frame_ok && !xrst_hit;
   endsequence
   sequence s_bad_end;
      frame_err && !xrst_hit;
   endsequence

   abort_keeps_cfg_a: assert property (s_bad_end |=>
      $stable(sys_cfg) && $stable(run_reg) && $stable(diag_cfg))
      else $error("aborted write changed a register");
   abort_flags_a: assert property (s_bad_end |=>
      fault_flag && xfer_err [*2])
      else $error("aborted write left fault flag low");
   run_latch_a: assert property ((s_good_end and sel == 2'h2) |=>
      run_reg == $past(frm.word) && $stable(diag_cfg))
      else $error("run write not latched");
   diag_sel_a: assert property ((s_good_end and sel == 2'h1) |=>
      diag_cfg == $past(frm.word) && $stable(run_reg))
      else $error("diagnostic config write misdecoded");
   access_clear_a: assert property ((s_good_end and !par_bad &&
      short_fault_i == 8'h00 && flag_set_i == 6'h00) |=> !fault_flag)
      else $error("completed access did not clear faults");
   table_restart_a: assert property ((s_good_end and sel != 2'h3)
      |=> tbl_idx == 5'h00)
      else $error("table index not restarted");
   table_step_a: assert property (tbl_take && !xrst_hit |=>
      tbl_idx == 5'($past(tbl_idx) + 5'h01))
      else $error("table index did not advance");
   table_full_a: assert property (tbl_wr && tbl_idx == 5'h10
      && !xrst_hit |=> tbl_idx == 5'h10 && $stable(tbl_mem[15]))
      else $error("write accepted after full table");
   parity_flag_a: assert property (par_bad |=>
      par_err && fault_flag)
      else $error("parity error not flagged");
   abort_restart_a: assert property (s_bad_end |=> tbl_idx == 5'h00)
      else $error("transfer error kept table index");
   ext_keep_table_a: assert property (xrst_hit |=>
      $stable(tbl_mem[0]) && !xfer_err && !par_err)
      else $error("external reset harmed table or kept errors");

endmodule

// ===== verif/sspr_master.sv
// Serial bus master model driving the register port link pins
module sspr_master (
   // Link pins toward the port
   output logic      serial_clk_o,
   output logic      serial_strobe_n_o,
   output logic      serial_data_o,
   input  wire logic serial_data_i,
   input  wire logic serial_data_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // Link clock idles high and stands still between frames
   initial begin
      serial_clk_o = 1'b1;
      serial_strobe_n_o = 1'b1;
      serial_data_o = 1'b0;
   end

   // One frame of n link clocks at 6 ns; n = 0 is a poll
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] rd, output logic oe_ok);
      rd = 16'h0000;
      serial_strobe_n_o = 1'b0;
      #2;
      oe_ok = serial_data_oe_i;
      rd[15] = serial_data_i;                    // Flag first
      for (int k = 0; k < n; k++) begin
         serial_clk_o = 1'b0;
         serial_data_o = (k < 16) ? w[15 - k] : ~w[0];
         #3 serial_clk_o = 1'b1;
         #3;
         if (k < 15) rd[14 - k] = serial_data_i;
      end
      serial_strobe_n_o = 1'b1;
      serial_data_o = ~serial_data_o;            // No stale value
      #2 oe_ok = oe_ok & ~serial_data_oe_i;
      #300;                                      // Lets word cross
   endtask
endmodule

// ===== verif/sspr_port_bench.sv
// Self-checking bench of the serial register port
module sspr_port_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RC = 4;                  // Short external reset
   logic                    clk_sys_i = 1'b0;
   logic                    rst_i = 1'b1;
   logic                    ext_n = 1'b1;
   logic [5:0]              angle = 6'h00;
   logic                    sclk, strb_n, sdi, sdo, oe, ok;
   sspr_pkg::sspr_level_t   lvl_a, lvl_b;
   sspr_pkg::sspr_sys_cfg_t cfg;
   logic [15:0]             diag_cfg, run, rd;
   logic [4:0]              inc;
   logic [6:0]              pct, dec;
   logic [2:0]              toff, tper;
   logic [7:0]              shrt = 8'h00;
   sspr_pkg::sspr_flags_t   flg = '0;
   int                      fails = 0;
   int                      n_checks = 0;

   always #10 clk_sys_i = ~clk_sys_i;

   sspr_master u_sspr_master (.serial_clk_o(sclk),
      .serial_strobe_n_o(strb_n), .serial_data_o(sdi),
      .serial_data_i(sdo), .serial_data_oe_i(oe));

   sspr_port #(.RST_CYCLES(RC)) u_sspr_port (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .serial_clk_i(sclk), .serial_strobe_n_i(strb_n),
      .serial_data_i(sdi), .serial_data_o(sdo), .serial_data_oe_o(oe),
      .external_reset_n_i(ext_n), .flag_set_i(flg),
      .short_fault_i(shrt), .step_angle_i(6'h2A),
      .table_angle_i(angle), .phase_a_level_o(lvl_a),
      .phase_b_level_o(lvl_b), .system_configuration_o(cfg),
      .diag_configuration_o(diag_cfg), .run_o(run),
      .step_increment_o(inc), .max_current_pct_o(pct),
      .fast_decay_cycles_o(dec), .off_time_select_o(toff),
      .period_select_o(tper));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(logic [15:0] w, int n = 16);
      u_sspr_master.xfer(w, n, rd, ok);
      chk("oe", ok, 1'b1);
   endtask
   task automatic look(logic [5:0] a, logic [5:0] ea, logic [5:0] eb);
      step(1);
      angle = a;
      step(2);
      chk("phase_a", lvl_a, ea);
      chk("phase_b", lvl_b, eb);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_cfg;
      logic [1:0] k;
      chk("pct_rst", pct, 7'h64);
      chk("dec_rst", dec, 7'h20);
      for (int i = 0; i < 4; i++) begin
         k = i[1:0];
         wr({3'h1, k, k, 1'b0, k, 2'h1, 3'h3, k[0]});
         chk("por", rd, (i == 0) ? 16'hEFFF : 16'h0000);
         chk("cfg", cfg, {1'b1, k, k, 1'b0, k, 2'h1, 3'h3, k[0]});
         chk("inc", inc, sspr_pkg::STEP_INC[k]);
         chk("pct", pct, sspr_pkg::MAX_CURRENT_PCT[k]);
         chk("dec", dec, sspr_pkg::FAST_DECAY_US[k] * 4);
         chk("toff", toff, k[0] ? 3'h0 : 3'h3);
         chk("tper", tper, k[0] ? 3'h3 : 3'h0);
      end
   endtask
   task automatic t_diag_abort;
      wr(16'h5021);
      chk("step_reg", rd, 16'h002A);
      chk("diag_cfg", diag_cfg, 16'h5021);
      wr(16'h8123, 15);
      wr(16'h8123, 17);
      chk("run_kept", run, sspr_pkg::RUN_RST);
      wr(16'h0000, 0);
      chk("poll", rd[15], 1'b1);
      wr(16'h8A81);
      chk("kept", rd, 16'h8000);
      chk("run", run, 16'h8A81);
   endtask
   task automatic t_short;
      step(1);
      flg.stall = 1'b1;                          // Stall flag alone
      step(1);
      flg = '0;
      step(1);
      wr(16'h5020);
      chk("flag_ff", rd, 16'h842A);
      step(1);
      shrt = 8'h05;                              // Short flags alone
      step(1);
      shrt = 8'h00;
      step(1);
      wr(16'h8A80);
      chk("short_ff", rd, 16'h8005);
      wr(16'h8A80);
      chk("cleared", rd, 16'h0000);
   endtask
   task automatic t_table;
      logic [5:0] v;
      wr(16'hC07F);                              // Partial load
      wr(16'hC07F);
      wr(16'h8A80);                              // Restarts index
      for (int i = 0; i < 17; i++) begin
         v = (i == 16) ? 6'h15 : 6'(i * 4 + 1);
         wr({9'h180, (i == 5) ^ ~^v, v});        // Entry 5 bad
         chk("parity", rd, (i == 6) ? 16'h8000 : 16'h0000);
      end
      look(6'h01, 6'h01, 6'h39);
      look(6'h06, 6'h15, 6'h25);
      look(6'h10, 6'h3D, 6'h00);
   endtask
   task automatic t_reset;
      wr(16'h0000, 3);                           // Sets error flag
      step(1);
      ext_n = 1'b0;
      step(RC + 10);
      chk("cfg_ext", cfg, sspr_pkg::SYS_CFG_RST[13:0]);
      ext_n = 1'b1;
      step(5);
      look(6'h01, 6'h01, 6'h39);
      wr(16'h5020);
      chk("diag_ext", rd, 16'h002A);
      rst_i = 1'b1;
      step(2);
      rst_i = 1'b0;
      step(5);
      look(6'h01, 6'h06, 6'h3F);
   endtask

   // Hang guard
   initial begin
      #100us;
      fails++;
      tally_and_finish;
   end

   initial begin
      step(20);
      rst_i = 1'b0;
      step(5);
      t_cfg;
      t_diag_abort;
      t_short;
      t_table;
      t_reset;
      tally_and_finish;
   end
endmodule
